// ==== inc/pin_mux_pkg.sv ====
// package: constants and types of the parallel port control pin mux
package pin_mux_pkg;
    localparam int NUM_PINS = 3;
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;
    // register byte addresses
    localparam logic [11:0] ADDR_BUS_CTRL = 12'h000;
    localparam logic [11:0] ADDR_MEM_GCTL1 = 12'h004;
    localparam logic [11:0] ADDR_GPIO_DIR = 12'h008;
    localparam logic [11:0] ADDR_GPIO_OUT = 12'h00C;
    localparam logic [11:0] ADDR_STATUS = 12'h010;
    // field positions
    localparam int BCR_HOLDER_LSB = 0;
    localparam int GCTL1_FLOAT_POS = 0;
    localparam int DIR_LSB = 0;
    localparam int OUT_LSB = 0;
    localparam int STS_FUNC_POS = 0;
    localparam int STS_HOLD_POS = 1;
    localparam int STS_OFF_POS = 2;
    localparam int STS_CLK_POS = 3;
    localparam int STS_PIN_LSB = 4;
    localparam int STS_STATE_LSB = 8;
    // reset values
    localparam logic [2:0] HOLDER_RESET = 3'h7;
    localparam logic FLOAT_RESET = 1'b0;
    localparam logic [2:0] DIR_RESET = 3'h0;
    localparam logic [2:0] OUT_RESET = 3'h0;
    localparam logic MEM_IDLE_LEVEL = 1'b1;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    typedef logic [NUM_PINS-1:0] pin_vec_t;
    typedef enum logic [1:0] {PAD_RESET, PAD_RUN, PAD_HOLD, PAD_OFF} pad_state_e;
endpackage : pin_mux_pkg

// ==== inc/pin_ctl_if.sv ====
// interface: pad control between the mux core and the pin drivers
`timescale 1ns/1ps
interface pin_ctl_if;
    import pin_mux_pkg::*;
    logic func_mem;
    pad_state_e pad;
    pin_vec_t gpio_dir;
    pin_vec_t gpio_out;
    pin_vec_t mem_val;
    logic mem_active;
    pin_vec_t holder_en;
    pin_vec_t pin_out;
    pin_vec_t pin_oe;
    pin_vec_t holder_out;
    modport ctl (output func_mem, pad, gpio_dir, gpio_out, mem_val, mem_active, holder_en,
                 input pin_out, pin_oe, holder_out);
    modport drv (input func_mem, pad, gpio_dir, gpio_out, mem_val, mem_active, holder_en,
                 output pin_out, pin_oe, holder_out);
endinterface : pin_ctl_if

// ==== rtl/strap_latch.sv ====
// strap latch: tracks the function strap in reset, frozen at release
`timescale 1ns/1ps
module strap_latch (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // synchronous reset, low active
    input wire logic clk_en, // state freezes while low
    input wire logic function_strap, // strap level, high selects memory
    output logic func_mem // latched selection
);
    import pin_mux_pkg::*;

    typedef struct packed {
        logic sel;
    } strap_state_s;

    strap_state_s state;
    strap_state_s next_state;

    ////////////////////////////////////////////////////////////////////////
    // follow the strap while reset is low, hold it once reset is high
    always_comb begin
        next_state = state;
        if (!rst_n) begin
            next_state.sel = function_strap;
        end
    end

    // register; reset loads the strap even with the enable low
    always_ff @(posedge sys_clk) begin
        if (!rst_n || clk_en) begin
            state <= next_state;
        end
    end

    assign func_mem = state.sel;
endmodule : strap_latch

// ==== rtl/pin_drive.sv ====
// pin drive: registered output value, enable and holder per pad
`timescale 1ns/1ps
module pin_drive (
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // synchronous reset, low active
    input wire logic clk_en, // state freezes while low
    pin_ctl_if.drv ctl // pad control from the core
);
    import pin_mux_pkg::*;

    typedef struct packed {
        pin_vec_t out;
        pin_vec_t oe;
        pin_vec_t hold;
    } drive_state_s;

    drive_state_s state;
    drive_state_s next_state;
    pin_vec_t out_c;
    pin_vec_t oe_c;
    logic run;

    ////////////////////////////////////////////////////////////////////////
    // only the run state drives; reset, hold and off float every pad
    assign run = (ctl.pad == PAD_RUN);

    // per pad: memory mode drives, gpio follows its direction bit
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pad
        assign oe_c[i] = run & (ctl.func_mem | ctl.gpio_dir[i]);
        assign out_c[i] = !run ? 1'b0 :
                          ctl.func_mem ? (ctl.mem_active ? ctl.mem_val[i] : MEM_IDLE_LEVEL) :
                          ctl.gpio_out[i];
    end

    ////////////////////////////////////////////////////////////////////////
    // next value of the pad registers
    always_comb begin
        next_state = state;
        if (clk_en) begin
            next_state.out = out_c;
            next_state.oe = oe_c;
            next_state.hold = ctl.holder_en;
        end
    end

    // register; reset floats all pads and turns the holders on
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state.out <= OUT_RESET;
            state.oe <= DIR_RESET;
            state.hold <= HOLDER_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign ctl.pin_out = state.out;
    assign ctl.pin_oe = state.oe;
    assign ctl.holder_out = state.hold;
endmodule : pin_drive

// ==== rtl/parallel_port_control_pin_mux.sv ====
// top: strap-selected gpio or memory control on three parallel port pads
`timescale 1ns/1ps
module parallel_port_control_pin_mux (
    input wire logic sys_clk, // 10 MHz system clock
    input wire logic rst_n, // synchronous reset, low active
    input wire logic clk_en, // state freezes while low
    // apb slave
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high writes
    input wire logic [pin_mux_pkg::APB_AW-1:0] paddr, // apb byte address
    input wire logic [pin_mux_pkg::APB_DW-1:0] pwdata, // apb write data
    output logic [pin_mux_pkg::APB_DW-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    // strap and mode pins
    input wire logic function_strap, // function strap
    input wire logic hold_request, // external hold request, high active
    input wire logic test_reset_n, // test reset, low active
    input wire logic emulation_pin_0, // emulation pin 0
    input wire logic emulation_off_pin, // emulation / off pin
    // memory controller side
    input wire logic mem_active, // controller owns the pad values
    input wire logic mem_byte_enable_2, // byte enable 2 from controller
    input wire logic mem_byte_enable_3, // byte enable 3 from controller
    input wire logic sdram_clock_enable, // sdram clock enable from controller
    // pads
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_in, // pad input levels
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_out, // pad output levels
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe, // pad output enables
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_holder_en, // bus holder enables
    output logic mem_clock_output, // memory clock output level
    output logic mem_clock_oe // memory clock output enable
);
    import pin_mux_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state of the core

    typedef struct packed {
        pad_state_e pad;
        pin_vec_t holder_en;
        logic clk_float;
        pin_vec_t gpio_dir;
        pin_vec_t gpio_out;
        pin_vec_t pin_in;
        logic mclk;
        logic mclk_oe;
        logic pready;
        logic pslverr;
        logic [APB_DW-1:0] prdata;
    } core_state_s;

    // current and next copy of the core state
    core_state_s state;
    core_state_s next_state;

    // decode helpers
    logic func_mem;
    logic off_req;
    logic hold_req;
    logic setup_ok;
    logic commit;
    logic mapped;
    logic [APB_DW-1:0] rd_value;
    // hold and off as software sees them
    logic in_hold;
    logic in_off;

    // pad control bundle towards the driver module
    pin_ctl_if ctl_bus ();

    ////////////////////////////////////////////////////////////////////////
    // strap capture

    // the strap flop follows the pin for the whole reset, so a strap
    // that settles late in reset is still the one that counts
    strap_latch u_strap (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .function_strap(function_strap),
        .func_mem(func_mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // mode requests

    // off mode: test reset low, emulation 0 high, emulation/off low
    // it comes straight from the pins and needs no register bit
    assign off_req = !test_reset_n && emulation_pin_0 && !emulation_off_pin;

    // hold only exists when the pads work for the memory interface;
    // in gpio mode that pin is an ordinary pad and must not float them
    assign hold_req = func_mem && hold_request;

    // pad state flags for the status word
    assign in_hold = (state.pad == PAD_HOLD);
    assign in_off = (state.pad == PAD_OFF);

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // first access cycle takes the answer, second one commits;
    // the answer is registered, so there is always one wait state;
    // a master that drops psel early leaves the answer pending, and its next access completes at once
    assign setup_ok = psel && penable && !state.pready;
    assign commit = psel && penable && state.pready;

    // address decode and read mux; reads have no side effects,
    // so holes and misaligned addresses read zero and flag an error
    always_comb begin
        rd_value = RDATA_ZERO;
        mapped = 1'b1;
        case (paddr)
            ADDR_BUS_CTRL: begin
                rd_value[BCR_HOLDER_LSB +: NUM_PINS] = state.holder_en;
            end
            ADDR_MEM_GCTL1: begin
                rd_value[GCTL1_FLOAT_POS] = state.clk_float;
            end
            ADDR_GPIO_DIR: begin
                rd_value[DIR_LSB +: NUM_PINS] = state.gpio_dir;
            end
            ADDR_GPIO_OUT: begin
                rd_value[OUT_LSB +: NUM_PINS] = state.gpio_out;
            end
            ADDR_STATUS: begin
                rd_value[STS_FUNC_POS] = func_mem;
                rd_value[STS_HOLD_POS] = in_hold;
                rd_value[STS_OFF_POS] = in_off;
                rd_value[STS_CLK_POS] = state.mclk_oe;
                rd_value[STS_PIN_LSB +: NUM_PINS] = state.pin_in;
                rd_value[STS_STATE_LSB +: 2] = state.pad;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state of the core
    always_comb begin
        next_state = state;
        if (clk_en) begin
            // pad input levels for status reads, one cycle late,
            // which is early enough for software polling
            next_state.pin_in = pad_in;

            // pad state; off outranks hold, hold outranks run; every
            // state leaves by the same priority, so a dropped request
            // goes straight back to run; reset forces the register below
            case (state.pad)
                PAD_RESET, PAD_RUN, PAD_HOLD, PAD_OFF: begin
                    if (off_req) begin
                        next_state.pad = PAD_OFF;
                    end else if (hold_req) begin
                        next_state.pad = PAD_HOLD;
                    end else begin
                        next_state.pad = PAD_RUN;
                    end
                end
                default: begin
                    next_state.pad = PAD_RESET;
                end
            endcase

            // memory clock runs in run and hold, floats by bit in hold;
            // the toggle flop keeps running under hold so an outside
            // master can still use the clock, the bit only gates the enable
            case (state.pad)
                PAD_RUN: begin
                    // run: clock always driven
                    next_state.mclk = !state.mclk;
                    next_state.mclk_oe = 1'b1;
                end
                PAD_HOLD: begin
                    next_state.mclk = !state.mclk;
                    next_state.mclk_oe = !state.clk_float;
                end
                PAD_OFF: begin
                    // off: clock parked low and floating
                    next_state.mclk = 1'b0;
                    next_state.mclk_oe = 1'b0;
                end
                default: begin
                    // reset: the same as off
                    next_state.mclk = 1'b0;
                    next_state.mclk_oe = 1'b0;
                end
            endcase

            // apb answer: one wait cycle, data and error registered;
            // preparing it one edge ahead keeps prdata, pready and
            // pslverr straight from flip-flops
            if (setup_ok) begin
                next_state.pready = 1'b1;
                next_state.pslverr = !mapped;
                next_state.prdata = pwrite ? RDATA_ZERO : rd_value;
            end else if (commit) begin
                next_state.pready = 1'b0;
                next_state.pslverr = 1'b0;
            end

            // writes take effect on the completing edge only; a write to
            // the status word or to a hole changes nothing
            if (commit && pwrite) begin
                case (paddr)
                    ADDR_BUS_CTRL: begin
                        next_state.holder_en = pwdata[BCR_HOLDER_LSB +: NUM_PINS];
                    end
                    ADDR_MEM_GCTL1: begin
                        next_state.clk_float = pwdata[GCTL1_FLOAT_POS];
                    end
                    ADDR_GPIO_DIR: begin
                        next_state.gpio_dir = pwdata[DIR_LSB +: NUM_PINS];
                    end
                    ADDR_GPIO_OUT: begin
                        next_state.gpio_out = pwdata[OUT_LSB +: NUM_PINS];
                    end
                    ADDR_STATUS: begin
                        next_state.gpio_out = state.gpio_out; // read only
                    end
                    default: begin
                        next_state.gpio_out = state.gpio_out;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core registers; reset wins over the clock enable, so a frozen
    // block still comes out of reset with every field at its start value
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state.pad <= PAD_RESET;
            state.holder_en <= HOLDER_RESET;
            state.clk_float <= FLOAT_RESET;
            state.gpio_dir <= DIR_RESET;
            state.gpio_out <= OUT_RESET;
            state.pin_in <= OUT_RESET;
            state.mclk <= 1'b0;
            state.mclk_oe <= 1'b0;
            // no answer may be pending when reset ends
            state.pready <= 1'b0;
            state.pslverr <= 1'b0;
            state.prdata <= RDATA_ZERO;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad control towards the drivers; the driver registers the pads
    // once more, so they change one edge after the core state

    // state and register fields the drivers need
    assign ctl_bus.func_mem = func_mem;
    assign ctl_bus.pad = state.pad;
    assign ctl_bus.gpio_dir = state.gpio_dir;
    assign ctl_bus.gpio_out = state.gpio_out;
    assign ctl_bus.holder_en = state.holder_en;
    assign ctl_bus.mem_active = mem_active;
    // first pad byte enable 2, second byte enable 3, third clock enable
    assign ctl_bus.mem_val = {sdram_clock_enable, mem_byte_enable_3, mem_byte_enable_2};

    // per-pad output, enable and holder registers
    pin_drive u_drive (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .ctl(ctl_bus.drv)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops, so no pad glitches while the
    // mode changes

    // pads and memory clock
    assign pad_out = ctl_bus.pin_out;
    assign pad_oe = ctl_bus.pin_oe;
    assign pad_holder_en = ctl_bus.holder_out;
    assign mem_clock_output = state.mclk;
    assign mem_clock_oe = state.mclk_oe;
    // apb answer
    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
endmodule : parallel_port_control_pin_mux

// ==== verification/pin_mux_monitor.sv ====
// checker: pad mux behaviour seen at the top-level ports
`timescale 1ns/1ps
module pin_mux_monitor (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset
    input wire logic clk_en, // run enable
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb write
    input wire logic [pin_mux_pkg::APB_AW-1:0] paddr, // apb address
    input wire logic [pin_mux_pkg::APB_DW-1:0] pwdata, // apb data
    input wire logic pready, // apb ready
    input wire logic function_strap, // strap
    input wire logic hold_request, // hold
    input wire logic test_reset_n, // test reset
    input wire logic emulation_pin_0, // emulation 0
    input wire logic emulation_off_pin, // emulation off
    input wire logic mem_active, // controller owns pads
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_out, // pad levels
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe, // pad enables
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_holder_en, // holders
    input wire logic mem_clock_output, // memory clock
    input wire logic mem_clock_oe // memory clock enable
);
    import pin_mux_pkg::*;
    logic sel_mem;
    logic flt;
    logic off;
    logic quiet;
    default clocking @(posedge sys_clk); endclocking
    ////////////////////////////////////////
    // selection seen at the last reset edge, float bit as last written
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sel_mem <= function_strap;
            flt <= FLOAT_RESET;
        end else if (psel && penable && pready && pwrite && paddr == ADDR_MEM_GCTL1) begin
            flt <= pwdata[GCTL1_FLOAT_POS];
        end
    end
    // off decode and no mode request pending
    assign off = !test_reset_n && emulation_pin_0 && !emulation_off_pin;
    assign quiet = clk_en && !hold_request && !off;
    ////////////////////////////////////////
    chk_reset_float: assert property (!rst_n |=> pad_oe == 3'h0 && !mem_clock_oe)
        else $error("pad driven in reset");
    chk_holder_reset: assert property (!rst_n |=> pad_holder_en == HOLDER_RESET)
        else $error("holders not on in reset");
    chk_mem_release: assert property ((!rst_n && function_strap) ##1 (rst_n && quiet) [*2]
        |=> pad_oe == 3'h7 && ($past(mem_active) || pad_out == 3'h7))
        else $error("memory pads not driving one");
    chk_gpio_release: assert property ((!rst_n && !function_strap) ##1 rst_n [*2] |=> pad_oe == 3'h0)
        else $error("gpio pads not inputs");
    chk_mem_driven: assert property (disable iff (!rst_n) (sel_mem && quiet) [*2] |=> pad_oe == 3'h7)
        else $error("memory selection lost");
    chk_hold_float: assert property (disable iff (!rst_n) (sel_mem && hold_request && clk_en) [*2]
        |=> pad_oe == 3'h0)
        else $error("pads driven in hold");
    chk_hold_clock: assert property (disable iff (!rst_n) (sel_mem && hold_request && clk_en && !off) [*2]
        |=> mem_clock_oe == !$past(flt))
        else $error("memory clock enable wrong in hold");
    chk_clock_runs: assert property (disable iff (!rst_n) !off ##1 (mem_clock_oe && clk_en)
        |=> mem_clock_output != $past(mem_clock_output))
        else $error("memory clock stopped");
    chk_off_float: assert property (disable iff (!rst_n) (off && clk_en) [*2]
        |=> pad_oe == 3'h0 && !mem_clock_oe)
        else $error("pads driven in off mode");
    cov_hold: cover property (rst_n && sel_mem && hold_request);
    cov_off: cover property (rst_n && off);
    cov_flt_write: cover property (psel && penable && pready && pwrite && paddr == ADDR_MEM_GCTL1);
endmodule : pin_mux_monitor
bind parallel_port_control_pin_mux pin_mux_monitor u_mon (.*);

// ==== verification/far_side_model.sv ====
// far side model: board signals, bus keeper and hold host
`timescale 1ns/1ps
module far_side_model (
    input wire logic sys_clk, // clock
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_out, // device levels
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_oe, // device enables
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] pad_holder_en, // holders
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] board_en, // board drives
    input wire logic [pin_mux_pkg::NUM_PINS-1:0] board_val, // board levels
    input wire logic host_take, // host wants the bus
    output logic [pin_mux_pkg::NUM_PINS-1:0] pad_in, // resolved levels
    output logic hold_request // hold to the device
);
    import pin_mux_pkg::*;
    pin_vec_t kept = 3'h0;
    // device first, then board, then keeper; an unkept line flips each cycle
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_en & board_val) | (~pad_oe & ~board_en & kept);
    always @(posedge sys_clk) begin
        kept <= pad_in ^ ~pad_holder_en;
    end
    // host asks for the bus only when it wants it
    assign hold_request = host_take;
endmodule : far_side_model

// ==== verification/tb.sv ====
// testbench: strap selection, pad modes and registers of the pin mux
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    import pin_mux_pkg::*;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic clk_en = 1'h1;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [APB_AW-1:0] paddr = 12'h000;
    logic [APB_DW-1:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, errv, hold_request, clk_lvl;
    logic function_strap = 1'h0, host_take = 1'h0;
    logic test_reset_n = 1'h1, emulation_pin_0 = 1'h0, emulation_off_pin = 1'h1;
    logic mem_active = 1'h0, mem_byte_enable_2 = 1'h1, mem_byte_enable_3 = 1'h1, sdram_clock_enable = 1'h1;
    pin_vec_t pad_in, pad_out, pad_oe, pad_holder_en, board_en = 3'h7, board_val = 3'h5;
    logic mem_clock_output, mem_clock_oe;
    int mismatches = 0, n_compared = 0, cycles = 0;
    parallel_port_control_pin_mux u_dut (.*);
    far_side_model u_far (.*);
    ////////////////////////////////////////
    // clock and hang limit
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            results();
        end
    end
    // one apb transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    // let n edges pass, then look at settled outputs
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : settle
    // reset for three cycles; strap only right at the last reset edge
    task automatic reset_with(input logic strap);
        @(posedge sys_clk);
        function_strap <= ~strap;
        rst_n <= 1'h0;
        settle(1);
        `CHK(pad_oe, 3'h0)
        `CHK(pad_holder_en, HOLDER_RESET)
        `CHK(mem_clock_oe, 1'h0)
        @(posedge sys_clk);
        function_strap <= strap;
        @(posedge sys_clk);
        rst_n <= 1'h1;
        settle(2);
    endtask : reset_with
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    ////////////////////////////////////////
    initial begin
        // gpio function
        reset_with(1'h0);
        `CHK(pad_oe, 3'h0)
        @(posedge sys_clk);
        function_strap <= 1'h1;
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rdv[STS_FUNC_POS], 1'h0)
        `CHK(rdv[STS_PIN_LSB +: NUM_PINS], 3'h5)
        apb(1'h0, ADDR_BUS_CTRL, 32'h0);
        `CHK(rdv, {29'h0, HOLDER_RESET})
        apb(1'h1, ADDR_GPIO_OUT, 32'h6);
        apb(1'h1, ADDR_GPIO_DIR, 32'h7);
        apb(1'h1, ADDR_BUS_CTRL, 32'h0);
        settle(3);
        `CHK(pad_oe, 3'h7)
        `CHK(pad_out, 3'h6)
        `CHK(pad_holder_en, 3'h0)
        apb(1'h0, 12'h020, 32'h0);
        `CHK(errv, 1'h1)
        `CHK(rdv, RDATA_ZERO)
        // memory function, second reset
        reset_with(1'h1);
        `CHK(pad_oe, 3'h7)
        `CHK(pad_out, 3'h7)
        `CHK(pad_holder_en, HOLDER_RESET)
        @(posedge sys_clk);
        function_strap <= 1'h0;
        apb(1'h0, ADDR_STATUS, 32'h0);
        `CHK(rdv[STS_FUNC_POS], 1'h1)
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            mem_active <= 1'h1;
            {sdram_clock_enable, mem_byte_enable_3, mem_byte_enable_2} <= 3'h1 << i;
            settle(3);
            `CHK(pad_out, 3'h1 << i)
        end
        // hold with running clock, then with floating clock
        @(posedge sys_clk);
        host_take <= 1'h1;
        settle(3);
        `CHK(pad_oe, 3'h0)
        `CHK(mem_clock_oe, 1'h1)
        clk_lvl = mem_clock_output;
        settle(0);
        `CHK(mem_clock_output, ~clk_lvl)
        @(posedge sys_clk);
        host_take <= 1'h0;
        apb(1'h1, ADDR_MEM_GCTL1, 32'h1);
        @(posedge sys_clk);
        host_take <= 1'h1;
        settle(3);
        `CHK(mem_clock_oe, 1'h0)
        `CHK(pad_oe, 3'h0)
        // off mode, then back to run
        @(posedge sys_clk);
        host_take <= 1'h0;
        test_reset_n <= 1'h0;
        emulation_pin_0 <= 1'h1;
        emulation_off_pin <= 1'h0;
        settle(3);
        `CHK(pad_oe, 3'h0)
        `CHK(mem_clock_oe, 1'h0)
        @(posedge sys_clk);
        test_reset_n <= 1'h1;
        settle(3);
        `CHK(pad_oe, 3'h7)
        // clock enable low freezes the memory clock and the pads
        @(posedge sys_clk);
        clk_en <= 1'h0;
        settle(1);
        clk_lvl = mem_clock_output;
        settle(2);
        `CHK(mem_clock_output, clk_lvl)
        `CHK(pad_oe, 3'h7)
        results();
    end
endmodule : tb
